// *** verilog/ufbt_core.sv ***
// Serial frame transmitter with register port, bit clocking and small receive buffer.
`timescale 1ns/10ps
`include "ufbt_map.svh"
module ufbt_core (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic rxd,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    input wire logic transfer_clock_pin_in,
    output logic transfer_clock_pin_out,
    output logic transfer_clock_pin_oe,
    output logic line_driver_enable,
    output logic irq_tx_done,
    output logic irq_tx_empty,
    output logic irq_rx_done
);
    // ------------------------------------------------------------
    // Decoding helpers.
    // ------------------------------------------------------------
    function automatic logic [3:0] char_bits(input logic [2:0] code);
        char_bits = (code == `UFBT_CHSZ_9) ? 4'h9 : (code[2] ? 4'h8 : 4'h5 + {2'h0, code[1:0]});
    endfunction

    function automatic logic [8:0] char_mask(input logic [3:0] n);
        char_mask = 9'h1ff >> (4'h9 - n);
    endfunction

    // ------------------------------------------------------------
    // Registers and pin synchronisers.
    // ------------------------------------------------------------
    logic [7:0] ctrl_a;
    logic [7:0] enable_control;
    logic [7:0] frame_format_control;
    logic [15:0] baud;
    logic tx_hi;
    ufbt_pkg::ufbt_word_t tx_buffer;
    logic buf_full;
    logic tx_done_flag;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic pin_s3;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= 3'h7;
            pin_s2 <= 3'h7;
            pin_s3 <= 1'b1;
        end else if (ce) begin
            pin_s1 <= {transfer_clock_pin_in, txd_in, rxd};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2[2];
        end
    end

    wire [1:0] mode = frame_format_control[`UFBT_FMT_MODE_HI:`UFBT_FMT_MODE_LO];
    wire [1:0] par_mode = frame_format_control[`UFBT_FMT_PAR_HI:`UFBT_FMT_PAR_LO];
    wire par_en = par_mode[1];
    wire stop2 = frame_format_control[`UFBT_FMT_STOP2];
    wire [3:0] nbits = char_bits(frame_format_control[`UFBT_FMT_CHSZ_HI:`UFBT_FMT_CHSZ_LO]);
    wire sync_mode = mode != `UFBT_MODE_ASYNC;
    wire slave = mode == `UFBT_MODE_SLAVE;
    wire tx_en = enable_control[`UFBT_EN_TX];
    wire rx_en = enable_control[`UFBT_EN_RX];
    wire od = enable_control[`UFBT_EN_OD];
    wire rx_line = ctrl_a[`UFBT_CA_LOOPBACK] ? pin_s2[1] : pin_s2[0];

    // ------------------------------------------------------------
    // Bit clocking.
    // ------------------------------------------------------------
    ufbt_pkg::ufbt_tx_e tx_st;
    ufbt_pkg::ufbt_tx_e next_tx_st;
    logic [4:0] smp;
    wire tx_busy = tx_st != ufbt_pkg::TX_IDLE;
    wire tx_act = tx_en | tx_busy | buf_full;

    wire [4:0] spb = sync_mode ? `UFBT_SPB_SYNC :
                     (enable_control[`UFBT_EN_CLK2X] ? `UFBT_SPB_DOUBLE : `UFBT_SPB_NORMAL);
    wire [4:0] spb_last = spb - 5'h01;
    wire smp_wrap = smp >= spb_last;

    ufbt_baud_if bif ();
    assign bif.baud = baud;
    assign bif.sync = sync_mode;
    assign bif.run = ~slave & (tx_act | rx_en);

    ufbt_baud_gen u_gen (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .bif(bif.gen)
    );

    // The slave takes each bit from a rising edge on the transfer clock pin.
    wire pin_rise = pin_s2[2] & ~pin_s3;
    wire bit_tick = slave ? pin_rise : (bif.tick & smp_wrap);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            smp <= 5'h00;
        end else if (ce && bif.tick) begin
            smp <= smp_wrap ? 5'h00 : smp + 5'h01;
        end
    end

    assign transfer_clock_pin_oe = (mode == `UFBT_MODE_MASTER) & tx_act;
    assign transfer_clock_pin_out = tx_busy & (smp == 5'h00);

    // ------------------------------------------------------------
    // Transmit path.
    // ------------------------------------------------------------
    ufbt_pkg::ufbt_word_t sh;
    ufbt_pkg::ufbt_word_t next_sh;
    logic [3:0] tx_bit;
    logic [3:0] next_tx_bit;
    logic par_bit;
    logic line;
    logic next_line;
    logic load;
    logic frame_end;

    wire [8:0] masked = tx_buffer & char_mask(nbits);
    wire next_par = (^masked) ^ (par_mode == `UFBT_PAR_ODD);

    always_comb begin
        next_tx_st = tx_st;
        next_sh = sh;
        next_tx_bit = tx_bit;
        load = 1'b0;
        frame_end = 1'b0;
        if (bit_tick) begin
            case (tx_st)
                ufbt_pkg::TX_IDLE: begin
                    load = buf_full;
                end
                ufbt_pkg::TX_START: begin
                    next_tx_st = ufbt_pkg::TX_DATA;
                    next_tx_bit = 4'h0;
                end
                ufbt_pkg::TX_DATA: begin
                    next_sh = {1'b0, sh[8:1]};
                    next_tx_bit = tx_bit + 4'h1;
                    if (tx_bit == nbits - 4'h1) begin
                        next_tx_st = par_en ? ufbt_pkg::TX_PAR : ufbt_pkg::TX_STOP1;
                    end
                end
                ufbt_pkg::TX_PAR: begin
                    next_tx_st = ufbt_pkg::TX_STOP1;
                end
                ufbt_pkg::TX_STOP1: begin
                    if (stop2) begin
                        next_tx_st = ufbt_pkg::TX_STOP2;
                    end else begin
                        load = buf_full;
                        frame_end = 1'b1;
                    end
                end
                ufbt_pkg::TX_STOP2: begin
                    load = buf_full;
                    frame_end = 1'b1;
                end
                default: begin
                    next_tx_st = ufbt_pkg::TX_IDLE;
                end
            endcase
            if (load) begin
                next_tx_st = ufbt_pkg::TX_START;
                next_sh = masked;
            end else if (frame_end) begin
                next_tx_st = ufbt_pkg::TX_IDLE;
            end
        end
    end

    // The line is low only for the start bit and zero data or parity bits.
    always_comb begin
        case (next_tx_st)
            ufbt_pkg::TX_START: next_line = 1'b0;
            ufbt_pkg::TX_DATA: next_line = next_sh[0];
            ufbt_pkg::TX_PAR: next_line = par_bit;
            default: next_line = 1'b1;
        endcase
    end

    wire tx_done_set = frame_end & ~buf_full;
    wire tx_wr_low = wr && addr == `UFBT_ADDR_TX_LOW && !buf_full && tx_en;
    wire tx_done_clr = wr && addr == `UFBT_ADDR_STATUS && wdata[`UFBT_ST_TXC];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st <= ufbt_pkg::TX_IDLE;
            sh <= 9'h000;
            tx_bit <= 4'h0;
            par_bit <= 1'b0;
            line <= 1'b1;
        end else if (ce) begin
            tx_st <= next_tx_st;
            sh <= next_sh;
            tx_bit <= next_tx_bit;
            line <= next_line;
            if (load) begin
                par_bit <= next_par;
            end
        end
    end

    // Single buffer entry ahead of the shifter; the loaded word frees it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_buffer <= 9'h000;
            buf_full <= 1'b0;
            tx_done_flag <= 1'b0;
        end else if (ce) begin
            if (tx_wr_low) begin
                tx_buffer <= {tx_hi, wdata};
                buf_full <= 1'b1;
            end else if (load) begin
                buf_full <= 1'b0;
            end
            tx_done_flag <= tx_done_set | (tx_done_flag & ~tx_done_clr);
        end
    end

    // Open drain only pulls low; otherwise the pin is driven while the path is active.
    assign txd_out = od ? 1'b0 : line;
    assign txd_oe = tx_act & (od ? ~line : 1'b1);
    assign line_driver_enable = ctrl_a[`UFBT_CA_DRIVER] & tx_busy;

    // ------------------------------------------------------------
    // Receive path and two-entry buffer.
    // ------------------------------------------------------------
    ufbt_pkg::ufbt_rx_e rx_st;
    ufbt_pkg::ufbt_rx_e next_rx_st;
    logic [4:0] rcnt;
    logic [4:0] next_rcnt;
    ufbt_pkg::ufbt_word_t rsh;
    ufbt_pkg::ufbt_word_t next_rsh;
    logic [3:0] rbit;
    logic [3:0] next_rbit;
    logic push;
    ufbt_pkg::ufbt_word_t rx_mem [2];
    logic rwp;
    logic rrp;
    logic [1:0] rcount;

    wire rx_mid = rcnt == (spb >> 1) - 5'h01;
    wire rx_full_bit = rcnt >= spb_last;
    wire [8:0] rx_word = rsh >> (4'h9 - nbits);

    always_comb begin
        next_rx_st = rx_st;
        next_rcnt = rcnt;
        next_rsh = rsh;
        next_rbit = rbit;
        push = 1'b0;
        case (rx_st)
            ufbt_pkg::RX_IDLE: begin
                if (!rx_line) begin
                    next_rx_st = ufbt_pkg::RX_START;
                    next_rcnt = 5'h00;
                    next_rsh = 9'h000;
                end
            end
            ufbt_pkg::RX_START: begin
                if (bif.tick) begin
                    next_rcnt = rcnt + 5'h01;
                    if (rx_mid) begin
                        next_rcnt = 5'h00;
                        next_rbit = 4'h0;
                        next_rx_st = rx_line ? ufbt_pkg::RX_IDLE : ufbt_pkg::RX_DATA;
                    end
                end
            end
            ufbt_pkg::RX_DATA: begin
                if (bif.tick) begin
                    next_rcnt = rx_full_bit ? 5'h00 : rcnt + 5'h01;
                    if (rx_full_bit) begin
                        next_rsh = (rbit == nbits) ? rsh : {rx_line, rsh[8:1]};
                        next_rbit = rbit + 4'h1;
                        if (rbit == nbits + {3'h0, par_en} - 4'h1) begin
                            next_rx_st = ufbt_pkg::RX_STOP;
                        end
                    end
                end
            end
            ufbt_pkg::RX_STOP: begin
                if (bif.tick) begin
                    next_rcnt = rx_full_bit ? 5'h00 : rcnt + 5'h01;
                    if (rx_full_bit) begin
                        push = 1'b1;
                        next_rx_st = ufbt_pkg::RX_IDLE;
                    end
                end
            end
            default: begin
                next_rx_st = ufbt_pkg::RX_IDLE;
            end
        endcase
        if (!rx_en) begin
            next_rx_st = ufbt_pkg::RX_IDLE;
            push = 1'b0;
        end
    end

    // The parity bit is never shifted in, so the word holds data only.
    wire [8:0] rx_store = rx_word;
    wire rx_pop = rd && addr == `UFBT_ADDR_RX_LOW && rcount != 2'h0;
    wire rx_push = push && rcount != `UFBT_RX_DEPTH;

    always_ff @(posedge clk) begin
        if (ce && rx_push) begin
            rx_mem[rwp] <= rx_store;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st <= ufbt_pkg::RX_IDLE;
            rcnt <= 5'h00;
            rsh <= 9'h000;
            rbit <= 4'h0;
            rwp <= 1'b0;
            rrp <= 1'b0;
            rcount <= 2'h0;
        end else if (ce) begin
            rx_st <= next_rx_st;
            rcnt <= next_rcnt;
            rsh <= next_rsh;
            rbit <= next_rbit;
            rwp <= rwp ^ rx_push;
            rrp <= rrp ^ rx_pop;
            rcount <= rcount + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    // ------------------------------------------------------------
    // Register port.
    // ------------------------------------------------------------
    wire rx_ready = rcount != 2'h0;
    wire [8:0] rx_head = rx_mem[rrp];
    wire [7:0] status = {rx_ready, tx_done_flag, ~buf_full, 5'h00};
    wire [7:0] rd_mux =
        addr == `UFBT_ADDR_RX_LOW ? (rx_ready ? rx_head[7:0] : 8'h00) :
        addr == `UFBT_ADDR_RX_HIGH ? {rx_ready, 6'h00, rx_ready & rx_head[8]} :
        addr == `UFBT_ADDR_STATUS ? status :
        addr == `UFBT_ADDR_CTRL_A ? ctrl_a :
        addr == `UFBT_ADDR_ENABLE ? enable_control :
        addr == `UFBT_ADDR_FORMAT ? frame_format_control :
        addr == `UFBT_ADDR_BAUD_LOW ? baud[7:0] :
        addr == `UFBT_ADDR_BAUD_HIGH ? baud[15:8] : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_a <= `UFBT_RST_CTRL;
            enable_control <= `UFBT_RST_CTRL;
            frame_format_control <= `UFBT_RST_CTRL;
            baud <= `UFBT_RST_BAUD;
            tx_hi <= 1'b0;
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? rd_mux : 8'h00;
            if (wr) begin
                case (addr)
                    `UFBT_ADDR_CTRL_A: ctrl_a <= wdata;
                    `UFBT_ADDR_ENABLE: enable_control <= wdata;
                    `UFBT_ADDR_FORMAT: frame_format_control <= wdata;
                    `UFBT_ADDR_BAUD_LOW: baud[7:0] <= wdata;
                    `UFBT_ADDR_BAUD_HIGH: baud[15:8] <= wdata;
                    `UFBT_ADDR_TX_HIGH: tx_hi <= wdata[0];
                    default: tx_hi <= tx_hi;
                endcase
            end
        end
    end

    // Three sources, each gated by its own enable.
    assign irq_tx_done = tx_done_flag & ctrl_a[`UFBT_CA_TXCIE];
    assign irq_tx_empty = ~buf_full & ctrl_a[`UFBT_CA_DREIE];
    assign irq_rx_done = rx_ready & ctrl_a[`UFBT_CA_RXCIE];
endmodule

// *** verilog/ufbt_map.svh ***
// Register map, field positions, reset values and bit timing counts of the serial transmitter.
//
// Behaviour
// - Each frame opens with one low start bit; stop bits and idle line are high.
// - Character length is five, six, seven, eight or nine data bits.
// - Optional even or odd parity bit sits after data, before first stop.
// - One or two stop bits close the frame, chosen by configuration.
// - After the last stop bit the next frame follows at once or line idles high.
// - Bit clock comes from the fractional generator unless the transfer clock pin drives it.
// - Divisor holds ten integer bits above six fraction bits; fraction dithers bit timing.
// - Samples per bit are 16 normal, 8 double speed and 2 synchronous.
// - Synchronous timing uses only the integer field; software writes the fraction as zero.
// - Writing the buffer starts sending; the word moves on once the shifter empties.
// - Transmit done flag sets when the frame ends and the buffer is empty.
// - Unused upper bits of short characters are dropped, never sent.
// - One transmit buffer entry ahead of the shifter; receive side is two deep.
// - Transmit done, buffer empty and receive done interrupts each have an enable.
// - A direction output enables an external line driver while sending.
// - One-wire mode shares the transmit pin; open drain enables the pin output only while it pulls low.
// - Disabling the transmitter waits until shifter and buffer are empty, then frees pin.
`ifndef UFBT_MAP_SVH
`define UFBT_MAP_SVH

`define UFBT_ADDR_RX_LOW 4'h0
`define UFBT_ADDR_RX_HIGH 4'h1
`define UFBT_ADDR_TX_LOW 4'h2
`define UFBT_ADDR_TX_HIGH 4'h3
`define UFBT_ADDR_STATUS 4'h4
`define UFBT_ADDR_CTRL_A 4'h5
`define UFBT_ADDR_ENABLE 4'h6
`define UFBT_ADDR_FORMAT 4'h7
`define UFBT_ADDR_BAUD_LOW 4'h8
`define UFBT_ADDR_BAUD_HIGH 4'h9

`define UFBT_ST_RXC 7
`define UFBT_ST_TXC 6
`define UFBT_ST_DRE 5
`define UFBT_CA_RXCIE 7
`define UFBT_CA_TXCIE 6
`define UFBT_CA_DREIE 5
`define UFBT_CA_LOOPBACK 3
`define UFBT_CA_DRIVER 0
`define UFBT_EN_RX 7
`define UFBT_EN_TX 6
`define UFBT_EN_OD 3
`define UFBT_EN_CLK2X 1
`define UFBT_FMT_MODE_HI 7
`define UFBT_FMT_MODE_LO 6
`define UFBT_FMT_PAR_HI 5
`define UFBT_FMT_PAR_LO 4
`define UFBT_FMT_STOP2 3
`define UFBT_FMT_CHSZ_HI 2
`define UFBT_FMT_CHSZ_LO 0

`define UFBT_MODE_ASYNC 2'h0
`define UFBT_MODE_MASTER 2'h1
`define UFBT_MODE_SLAVE 2'h2
`define UFBT_PAR_EVEN 2'h2
`define UFBT_PAR_ODD 2'h3
`define UFBT_CHSZ_9 3'h7

`define UFBT_RST_CTRL 8'h00
`define UFBT_RST_BAUD 16'h0000

`define UFBT_SPB_NORMAL 5'h10
`define UFBT_SPB_DOUBLE 5'h08
`define UFBT_SPB_SYNC 5'h02
`define UFBT_FRAC_STEP 17'h00040
`define UFBT_RX_DEPTH 2'h2

`endif

// *** verilog/ufbt_pkg.sv ***
// Types shared by the serial transmitter modules.
package ufbt_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} ufbt_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufbt_rx_e;
    typedef logic [8:0] ufbt_word_t;
endpackage

// *** verilog/ufbt_baud_if.sv ***
// Interface between the core and its fractional baud generator.
`timescale 1ns/10ps
interface ufbt_baud_if;
    logic [15:0] baud;
    logic sync;
    logic run;
    logic tick;
    modport gen (input baud, input sync, input run, output tick);
    modport user (output baud, output sync, output run, input tick);
endinterface

// *** verilog/ufbt_baud_gen.sv ***
// Fractional baud generator producing one sample tick per divisor period.
`timescale 1ns/10ps
`include "ufbt_map.svh"
module ufbt_baud_gen (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    ufbt_baud_if.gen bif
);
    logic [16:0] acc;
    // Synchronous mode keeps only the integer field of the divisor.
    wire [15:0] div = bif.sync ? {bif.baud[15:6], 6'h00} : bif.baud;
    // Adding 64 per clock and wrapping at the divisor gives 64*fclk/divisor ticks.
    wire [16:0] sum = acc + `UFBT_FRAC_STEP;
    wire hit = sum >= {1'b0, div};
    wire [16:0] next_acc = hit ? sum - {1'b0, div} : sum;

    assign bif.tick = bif.run & hit;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= 17'h00000;
        end else if (ce) begin
            acc <= bif.run ? next_acc : 17'h00000;
        end
    end
endmodule

// *** sim/ufbt_core_checker.sv ***
// Assertion checker bound to the serial transmitter core.
`timescale 1ns/10ps
`include "ufbt_map.svh"
module ufbt_core_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic transfer_clock_pin_oe,
    input wire logic line_driver_enable,
    input wire logic irq_tx_done,
    input wire logic irq_tx_empty,
    input wire logic irq_rx_done
);
    logic [7:0] ctla;
    logic [7:0] ena;
    logic [7:0] fmt;
    wire line = txd_oe ? txd_out : 1'b1;
    wire take = ce && wr;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctla <= 8'h00;
            ena <= 8'h00;
            fmt <= 8'h00;
        end else if (take) begin
            ctla <= (addr == `UFBT_ADDR_CTRL_A) ? wdata : ctla;
            ena <= (addr == `UFBT_ADDR_ENABLE) ? wdata : ena;
            fmt <= (addr == `UFBT_ADDR_FORMAT) ? wdata : fmt;
        end
    end
    // ----------------------------------------
    // Checks on the line and the flags.
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_start_run;
        fmt[7:6] == `UFBT_MODE_ASYNC && $fell(line) |=> (!line) [*7];
    endproperty
    a_start_run: assert property (p_start_run) else $error("low bit too short");
    property p_done_idle;
        $rose(irq_tx_done) |-> line;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");
    property p_done_en;
        irq_tx_done |-> ctla[`UFBT_CA_TXCIE];
    endproperty
    a_done_en: assert property (p_done_en) else $error("done irq unmasked");
    property p_empty_en;
        irq_tx_empty |-> ctla[`UFBT_CA_DREIE];
    endproperty
    a_empty_en: assert property (p_empty_en) else $error("empty irq unmasked");
    property p_rx_en;
        irq_rx_done |-> ctla[`UFBT_CA_RXCIE];
    endproperty
    a_rx_en: assert property (p_rx_en) else $error("rx irq unmasked");
    property p_od_low;
        ena[`UFBT_EN_OD] && txd_oe |-> !txd_out;
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain drove high");
    property p_drv_frame;
        ctla[`UFBT_CA_DRIVER] && !line |-> line_driver_enable;
    endproperty
    a_drv_frame: assert property (p_drv_frame) else $error("driver off in frame");
    property p_drv_en;
        line_driver_enable |-> ctla[`UFBT_CA_DRIVER];
    endproperty
    a_drv_en: assert property (p_drv_en) else $error("driver on while off");
    property p_clk_out;
        fmt[7:6] == `UFBT_MODE_MASTER && !line |-> transfer_clock_pin_oe;
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("no bit clock out");
endmodule
bind ufbt_core ufbt_core_checker i_ufbt_core_checker (
    .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .txd_out(txd_out), .txd_oe(txd_oe), .transfer_clock_pin_oe(transfer_clock_pin_oe),
    .line_driver_enable(line_driver_enable), .irq_tx_done(irq_tx_done),
    .irq_tx_empty(irq_tx_empty), .irq_rx_done(irq_rx_done)
);

// *** sim/ufbt_line_peer.sv ***
// Remote receiver model that decodes frames from the transmit line.
`timescale 1ns/10ps
module ufbt_line_peer (
    input wire logic clk,
    input wire logic line,
    input wire logic [3:0] nbits,
    input wire logic par_en,
    input wire logic stop2,
    input int spb,
    output logic [8:0] word,
    output logic par_bit,
    output logic stop_ok,
    output int frames,
    output int gap
);
    int cyc = 0;
    int t0 = 0;
    always @(negedge clk) cyc <= cyc + 1;
    // ----------------------------------------
    // Decoder sampling the middle of each bit.
    // ----------------------------------------
    initial begin
        word = 9'h000;
        par_bit = 1'b0;
        stop_ok = 1'b0;
        frames = 0;
        gap = 0;
        forever begin
            @(negedge clk);
            if (line === 1'b0) begin
                gap = cyc - t0;
                t0 = cyc;
                word = 9'h000;
                repeat (spb / 2) @(negedge clk);
                for (int i = 0; i < nbits; i++) begin
                    repeat (spb) @(negedge clk);
                    word[i] = line;
                end
                if (par_en) begin
                    repeat (spb) @(negedge clk);
                    par_bit = line;
                end
                repeat (spb) @(negedge clk);
                stop_ok = line;
                if (stop2) begin
                    repeat (spb) @(negedge clk);
                    stop_ok = stop_ok & line;
                end
                frames++;
            end
        end
    end
endmodule

// *** sim/usart_frame_baud_transmit_test.sv ***
// Self-checking bench for the serial transmitter core.
`timescale 1ns/10ps
`include "ufbt_map.svh"
module usart_frame_baud_transmit_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic txd_out, txd_oe, irq_txc, irq_rxc, pbit, pstop;
    logic [8:0] pword;
    logic [3:0] nb = 4'h8;
    logic pe = 1'b0;
    logic s2 = 1'b0;
    int spb = 16;
    int frames, gap;
    int num_errors = 0;
    int comparisons = 0;
    int t_chsz[6] = '{0, 1, 2, 3, 7, 3};
    int t_par[6] = '{2, 3, 0, 2, 3, 0};
    int t_s2[6] = '{0, 1, 0, 1, 0, 0};
    int t_x2[6] = '{0, 0, 1, 1, 0, 0};
    int t_baud[6] = '{64, 64, 64, 64, 96, 128};
    int t_spb[6] = '{16, 16, 8, 8, 24, 4};
    wire line = txd_oe ? txd_out : 1'b1;
    always #20 clk = ~clk;
    ufbt_core i_ufbt_core (
        .clk(clk), .rst_b(rst_b), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rxd(line), .txd_in(line), .txd_out(txd_out), .txd_oe(txd_oe),
        .transfer_clock_pin_in(1'b0), .transfer_clock_pin_out(), .transfer_clock_pin_oe(),
        .line_driver_enable(), .irq_tx_done(irq_txc), .irq_tx_empty(), .irq_rx_done(irq_rxc)
    );
    ufbt_line_peer i_ufbt_line_peer (
        .clk(clk), .line(line), .nbits(nb), .par_en(pe), .stop2(s2), .spb(spb),
        .word(pword), .par_bit(pbit), .stop_ok(pstop), .frames(frames), .gap(gap)
    );
    // ----------------------------------------
    // Shared tasks.
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wait_frames(input int n);
        for (int k = 0; k < 5000 && frames < n; k++) @(negedge clk);
        if (frames < n) begin
            num_errors++;
            $display("ERROR frame count expected %0d seen %0d", n, frames);
            wrap_up();
        end
    endtask
    initial begin
        logic [7:0] r;
        logic [7:0] h;
        int d;
        int fl;
        int k;
        int base;
        int exq[$];
        int rxq[$];
        d = $urandom(23937);
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        bus_rd(4'hf, r);
        check("unmapped read", r, 0);
        bus_rd(`UFBT_ADDR_BAUD_HIGH, r);
        check("divisor reset", r, 0);
        for (int c = 0; c < 6; c++) begin
            nb <= 4'((t_chsz[c] == 7) ? 9 : t_chsz[c] + 5);
            pe <= t_par[c] > 1;
            s2 <= t_s2[c][0];
            spb <= t_spb[c];
            fl = (2 + ((t_chsz[c] == 7) ? 9 : t_chsz[c] + 5) + (t_par[c] > 1) + t_s2[c]) * t_spb[c];
            base = frames;
            bus_wr(`UFBT_ADDR_CTRL_A, {3'h7, 1'b0, c == 0, 3'h1});
            bus_wr(`UFBT_ADDR_ENABLE, {4'h0, c == 0, 3'h0});
            bus_wr(`UFBT_ADDR_BAUD_LOW, t_baud[c][7:0]);
            bus_wr(`UFBT_ADDR_BAUD_HIGH, 8'h00);
            bus_wr(`UFBT_ADDR_FORMAT, {1'b0, c == 5, t_par[c][1:0], t_s2[c][0], t_chsz[c][2:0]});
            bus_wr(`UFBT_ADDR_ENABLE, {2'h3, 2'h0, c == 0, 1'b0, t_x2[c][0], 1'b0});
            for (k = 0; k < 3; k++) begin
                d = $urandom() & 9'h1ff;
                if (k < 2) begin
                    exq.push_back(d & ((1 << nb) - 1));
                    rxq.push_back(d & ((1 << nb) - 1));
                    bus_wr(`UFBT_ADDR_TX_HIGH, {7'h00, d[8]});
                end
                bus_wr(`UFBT_ADDR_TX_LOW, d[7:0]);
                r = 8'h00;
                for (int p = 0; p < 40 && k == 0 && r[5] !== 1'b1; p++) bus_rd(4'h4, r);
                if (k == 0) check("buffer freed", r[5], 1);
                if (k == 1) bus_rd(`UFBT_ADDR_STATUS, r);
                if (k == 1) check("buffer full", r[5], 0);
            end
            bus_wr(`UFBT_ADDR_ENABLE, {2'h2, 2'h0, c == 0, 1'b0, t_x2[c][0], 1'b0});
            for (k = 1; k <= 2; k++) begin
                wait_frames(base + k);
                d = exq.pop_front();
                check("frame data", pword, d);
                if (pe) check("parity", pbit, ($countones(d) + (t_par[c] == 3)) % 2);
                check("stop level", pstop, 1);
            end
            check("frame spacing", gap, fl);
            repeat (fl) @(negedge clk);
            check("refused word", frames, base + 2);
            check("pin released", txd_oe, 0);
            check("done irq", irq_txc, 1);
            bus_wr(`UFBT_ADDR_STATUS, 8'h40);
            bus_rd(`UFBT_ADDR_STATUS, r);
            check("done cleared", r[6], 0);
            if (c < 5) check("rx irq", irq_rxc, 1);
            for (k = 0; k < 2 && c < 5; k++) begin
                bus_rd(`UFBT_ADDR_RX_HIGH, h);
                bus_rd(`UFBT_ADDR_RX_LOW, r);
                check("rx word", {h[0], r}, rxq.pop_front());
            end
            rxq.delete();
        end
        wrap_up();
    end
endmodule
